// ==== cid_params.svh ====
// Constants for the inc/dec/invert, interrupt-enable and relative-jump unit.
// Assumes a 32-bit AHB-Lite register window with byte addresses below 8'h20.
`ifndef CID_PARAMS_SVH
`define CID_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CID_OFF_OPERAND  8'h00
`define CID_OFF_STATUS   8'h04
`define CID_OFF_PC       8'h08
`define CID_OFF_COMMAND  8'h0c
`define CID_OFF_RESULT   8'h10
`define CID_OFF_INFO     8'h14

// ----------------------------------------------------------------------
// Status word bit positions and masks
// ----------------------------------------------------------------------
`define CID_ST_C         0
`define CID_ST_Z         1
`define CID_ST_N         2
`define CID_ST_IEN       3
`define CID_ST_CORE_HALT 4
`define CID_ST_OSC_OFF   5
`define CID_ST_V         8
`define CID_IEN_SET_MASK 16'h0008
`define CID_IEN_CLR_MASK 16'hfff7

// ----------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------
`define CID_CMD_OP_LSB   0
`define CID_CMD_OP_MSB   3
`define CID_CMD_BYTE     4
`define CID_CMD_OFS_LSB  16
`define CID_CMD_OFS_MSB  25

// ----------------------------------------------------------------------
// Operand constants and reset values
// ----------------------------------------------------------------------
`define CID_ADD_ONE      16'h0001
`define CID_ADD_TWO      16'h0002
`define CID_SUB_TWO      16'hfffe
`define CID_ST_RESET     16'h0000
`define CID_PC_RESET     20'h00000
`define CID_DATA_RESET   16'h0000

`endif

// ==== cid_pkg.sv ====
// Types shared by the execution slice and its register shell.
// Assumes the constants header is compiled alongside.
package cid_pkg;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        no_op,
        double_decrement_op,
        increment_op,
        double_increment_op,
        bitwise_complement_op,
        irq_disable_op,
        irq_enable_op,
        jump_on_carry,
        jump_on_zero_flag
    } cid_op_e;

    // ------------------------------------------------------------------
    // Execution carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        cid_op_e     op;
        logic        byte_mode;
        logic [15:0] dst;
        logic [15:0] status_word;
    } cid_alu_in_s;

    typedef struct packed {
        logic [15:0] result;
        logic [15:0] status_word;
        logic        writes_dst;
    } cid_alu_out_s;

    // ------------------------------------------------------------------
    // Whole state of the register shell
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] operand;
        logic [15:0] status_word;
        logic [19:0] pc;
        logic [31:0] command;
        logic [15:0] result;
        logic        jump_taken;
        logic        irq_hold;
        logic        irq_take;
        logic        ph_valid;
        logic        ph_write;
        logic        ph_mapped;
        logic [7:0]  ph_addr;
        logic [31:0] hrdata;
        logic        hreadyout;
    } cid_state_s;

endpackage

// ==== cid_alu.sv ====
// Arithmetic and status-word slice for one executed operation.
// Purely combinational; assumes a clocked caller that registers the outputs.
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_alu (
    input  cid_pkg::cid_alu_in_s  alu_in,
    output cid_pkg::cid_alu_out_s alu_out
);

    logic [15:0] addend;
    logic [16:0] sum_w;
    logic [8:0]  sum_b;
    logic [15:0] res;
    logic        a_sign;
    logic        k_sign;
    logic        r_sign;
    logic        r_zero;
    logic        carry;

    always_comb
    begin
        unique case (alu_in.op)
            cid_pkg::double_decrement_op: addend = `CID_SUB_TWO;
            cid_pkg::increment_op:        addend = `CID_ADD_ONE;
            default:                      addend = `CID_ADD_TWO;
        endcase
        sum_w = {1'b0, alu_in.dst} + {1'b0, addend};
        sum_b = {1'b0, alu_in.dst[7:0]} + {1'b0, addend[7:0]};
        if (alu_in.op == cid_pkg::bitwise_complement_op)
        begin
            res   = ~alu_in.dst;
            carry = 1'b0;
        end
        else
        begin
            res   = sum_w[15:0];
            carry = alu_in.byte_mode ? sum_b[8] : sum_w[16];
        end
        // Byte forms work on the low byte, sign in bit 7
        if (alu_in.byte_mode)
        begin
            res    = {8'h00, res[7:0]};
            a_sign = alu_in.dst[7];
            k_sign = addend[7];
            r_sign = res[7];
            r_zero = (res[7:0] == 8'h00);
        end
        else
        begin
            a_sign = alu_in.dst[15];
            k_sign = addend[15];
            r_sign = res[15];
            r_zero = (res == 16'h0000);
        end

        alu_out             = '0;
        alu_out.status_word = alu_in.status_word;
        alu_out.result      = res;
        unique case (alu_in.op)
            cid_pkg::double_decrement_op,
            cid_pkg::increment_op,
            cid_pkg::double_increment_op:
            begin
                alu_out.writes_dst = 1'b1;
                alu_out.status_word[`CID_ST_N] = r_sign;
                alu_out.status_word[`CID_ST_Z] = r_zero;
                alu_out.status_word[`CID_ST_C] = carry;
                // Overflow when both operands agree in sign and result does not
                alu_out.status_word[`CID_ST_V] = (a_sign == k_sign) &&
                                                 (r_sign != a_sign);
            end
            cid_pkg::bitwise_complement_op:
            begin
                alu_out.writes_dst = 1'b1;
                alu_out.status_word[`CID_ST_N] = r_sign;
                alu_out.status_word[`CID_ST_Z] = r_zero;
                alu_out.status_word[`CID_ST_C] = ~r_zero;
                alu_out.status_word[`CID_ST_V] = a_sign;
            end
            cid_pkg::irq_disable_op:
                alu_out.status_word = alu_in.status_word & `CID_IEN_CLR_MASK;
            cid_pkg::irq_enable_op:
                alu_out.status_word = alu_in.status_word | `CID_IEN_SET_MASK;
            default:
                alu_out.status_word = alu_in.status_word;
        endcase
    end

endmodule

// ==== cid_unit.sv ====
// Register shell and program-counter logic for the inc/dec/invert unit.
// Assumes a single AHB-Lite master and one slave on the bus, hready = hreadyout.
`timescale 1ns/1ps
`include "cid_params.svh"

module cid_unit (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        irq_request,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq_take,
    output logic             global_irq_enable,
    output logic             core_halt_bit,
    output logic             oscillator_off_bit
);

    // ------------------------------------------------------------------
    // Reset image of the whole state
    // ------------------------------------------------------------------
    localparam cid_pkg::cid_state_s STATE_RESET = '{
        operand:     `CID_DATA_RESET,
        status_word: `CID_ST_RESET,
        pc:          `CID_PC_RESET,
        command:     32'h0000_0000,
        result:      `CID_DATA_RESET,
        jump_taken:  1'b0,
        irq_hold:    1'b0,
        irq_take:    1'b0,
        ph_valid:    1'b0,
        ph_write:    1'b0,
        ph_mapped:   1'b0,
        ph_addr:     8'h00,
        hrdata:      32'h0000_0000,
        hreadyout:   1'b1
    };

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [31:0] a);
        logic hit;
        hit = 1'b0;
        if (a[31:8] == 24'h000000 && a[1:0] == 2'b00)
        begin
            unique case (a[7:0])
                `CID_OFF_OPERAND,
                `CID_OFF_STATUS,
                `CID_OFF_PC,
                `CID_OFF_COMMAND,
                `CID_OFF_RESULT,
                `CID_OFF_INFO: hit = 1'b1;
                default:       hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    function automatic cid_pkg::cid_op_e op_of(input logic [31:0] cmd);
        cid_pkg::cid_op_e op;
        unique case (cmd[`CID_CMD_OP_MSB:`CID_CMD_OP_LSB])
            4'h1:    op = cid_pkg::double_decrement_op;
            4'h2:    op = cid_pkg::increment_op;
            4'h3:    op = cid_pkg::double_increment_op;
            4'h4:    op = cid_pkg::bitwise_complement_op;
            4'h5:    op = cid_pkg::irq_disable_op;
            4'h6:    op = cid_pkg::irq_enable_op;
            4'h7:    op = cid_pkg::jump_on_carry;
            4'h8:    op = cid_pkg::jump_on_zero_flag;
            default: op = cid_pkg::no_op;
        endcase
        return op;
    endfunction

    function automatic logic [31:0] read_mux(input cid_pkg::cid_state_s s,
                                             input logic [7:0]          a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `CID_OFF_OPERAND: v = {16'h0000, s.operand};
            `CID_OFF_STATUS:  v = {16'h0000, s.status_word};
            `CID_OFF_PC:      v = {12'h000, s.pc};
            `CID_OFF_COMMAND: v = s.command;
            `CID_OFF_RESULT:  v = {16'h0000, s.result};
            `CID_OFF_INFO:    v = {29'h0000_0000, s.irq_take, s.irq_hold, s.jump_taken};
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // State and execution slice
    // ------------------------------------------------------------------
    cid_pkg::cid_state_s   state_q;
    cid_pkg::cid_state_s   state_d;
    cid_pkg::cid_alu_in_s  alu_in;
    cid_pkg::cid_alu_out_s alu_out;
    cid_pkg::cid_op_e      new_op;
    logic                  addr_take;
    logic                  wr_cmd;
    logic                  jump_cond;
    logic [19:0]           jump_disp;

    assign new_op = op_of(hwdata);

    always_comb
    begin
        alu_in             = '0;
        alu_in.op          = new_op;
        alu_in.byte_mode   = hwdata[`CID_CMD_BYTE];
        alu_in.dst         = state_q.operand;
        alu_in.status_word = state_q.status_word;
    end

    cid_alu u_alu (
        .alu_in  (alu_in),
        .alu_out (alu_out)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        addr_take = hsel && hready && htrans[1];
        wr_cmd    = state_q.ph_valid && state_q.ph_write &&
                    state_q.ph_mapped && (state_q.ph_addr == `CID_OFF_COMMAND);

        // Jump condition from the flags as they stand before the command
        unique case (new_op)
            cid_pkg::jump_on_carry:     jump_cond = state_q.status_word[`CID_ST_C];
            cid_pkg::jump_on_zero_flag: jump_cond = state_q.status_word[`CID_ST_Z];
            default:                    jump_cond = 1'b0;
        endcase
        // Word offset doubled and sign extended, wraps over 20 bits
        jump_disp = {{9{hwdata[`CID_CMD_OFS_MSB]}},
                     hwdata[`CID_CMD_OFS_MSB:`CID_CMD_OFS_LSB], 1'b0};

        // Data phase of a write
        if (state_q.ph_valid && state_q.ph_write && state_q.ph_mapped)
        begin
            unique case (state_q.ph_addr)
                `CID_OFF_OPERAND: state_d.operand     = hwdata[15:0];
                `CID_OFF_STATUS:  state_d.status_word = hwdata[15:0];
                `CID_OFF_PC:      state_d.pc          = hwdata[19:0];
                `CID_OFF_COMMAND: state_d.command     = hwdata;
                default:          state_d.command     = state_q.command;
            endcase
        end

        // Command execution
        if (wr_cmd)
        begin
            state_d.status_word = alu_out.status_word;
            if (alu_out.writes_dst)
            begin
                state_d.operand = alu_out.result;
                state_d.result  = alu_out.result;
            end
            state_d.jump_taken = jump_cond;
            if (jump_cond)
            begin
                state_d.pc = state_q.pc + jump_disp;
            end
            // Hold off interrupts until one more command has executed
            state_d.irq_hold = (new_op == cid_pkg::irq_enable_op);
        end

        state_d.irq_take = state_d.status_word[`CID_ST_IEN] && irq_request &&
                           !state_d.irq_hold;

        // Address phase capture
        if (hready)
        begin
            state_d.ph_valid  = addr_take;
            state_d.ph_write  = hwrite;
            state_d.ph_mapped = addr_mapped(haddr);
            state_d.ph_addr   = haddr[7:0];
        end

        // Read data prepared from the state that this edge will hold
        if (addr_take && !hwrite && addr_mapped(haddr))
        begin
            state_d.hrdata = read_mux(state_d, haddr[7:0]);
        end
        else if (addr_take)
        begin
            state_d.hrdata = 32'h0000_0000;
        end

        state_d.hreadyout = 1'b1;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout          = state_q.hreadyout;
    assign hrdata             = state_q.hrdata;
    assign hresp              = 1'b0;
    assign irq_take           = state_q.irq_take;
    assign global_irq_enable  = state_q.status_word[`CID_ST_IEN];
    assign core_halt_bit      = state_q.status_word[`CID_ST_CORE_HALT];
    assign oscillator_off_bit = state_q.status_word[`CID_ST_OSC_OFF];

    // hsize is accepted but only whole-word transfers are defined
    logic unused_size;
    assign unused_size = ^hsize;

endmodule

// ==== cid_unit_properties.sv ====
// Checker for the mode bits, interrupt hold and bus answer of the unit.
// Assumes one AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/1ps

module cid_unit_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        irq_take,
    input wire logic        global_irq_enable,
    input wire logic        core_halt_bit,
    input wire logic        oscillator_off_bit
);
    // ------------------------------------------------------------------
    // Data phase tracking
    // ------------------------------------------------------------------
    logic       dp_q;
    logic       dpw_q;
    logic [7:0] dpa_q;
    logic       cmd;
    logic [3:0] op;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_q  <= 1'b0;
            dpw_q <= 1'b0;
            dpa_q <= 8'h00;
        end
        else if (hready)
        begin
            dp_q  <= hsel && htrans[1];
            dpw_q <= hwrite;
            dpa_q <= haddr[7:0];
        end
    end

    assign cmd = dp_q && dpw_q && dpa_q == 8'h0c;
    assign op  = hwdata[3:0];

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence cmd_s(logic [3:0] code);
        cmd && op == code;
    endsequence

    sequence power_kept_s;
        $stable(core_halt_bit) && $stable(oscillator_off_bit);
    endsequence

    a_disable_clears_ie: assert property (
        cmd_s(4'h5) |=> !global_irq_enable) else $error("enable bit left set");
    a_disable_keeps_power: assert property (
        cmd_s(4'h5) |=> power_kept_s) else $error("power bits moved on disable");
    a_enable_sets_ie: assert property (
        cmd_s(4'h6) |=> global_irq_enable ##0 power_kept_s) else $error("enable op wrong");
    a_enable_defers_irq: assert property (
        cmd_s(4'h6) |=> !irq_take) else $error("irq taken right after enable");
    a_arith_keeps_mode: assert property (
        cmd && op inside {[4'h1:4'h4]} |=> power_kept_s ##0 $stable(global_irq_enable))
        else $error("mode bits moved by arithmetic");
    a_jump_keeps_mode: assert property (
        cmd && op inside {4'h7, 4'h8} |=> power_kept_s ##0 $stable(global_irq_enable))
        else $error("mode bits moved by jump");
    a_ie_needs_cause: assert property (
        $changed(global_irq_enable) |-> $past(dp_q && dpw_q && dpa_q inside {8'h04, 8'h0c}))
        else $error("enable bit moved without a write");
    a_unmapped_reads_zero: assert property (
        dp_q && !dpw_q && dpa_q > 8'h14 |-> hrdata == 32'h0) else $error("unmapped read not zero");
    a_bus_okay: assert property (
        hreadyout && !hresp) else $error("bus answer not ready and okay");
endmodule

bind cid_unit cid_unit_props cid_unit_props_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_take(irq_take),
    .global_irq_enable(global_irq_enable), .core_halt_bit(core_halt_bit),
    .oscillator_off_bit(oscillator_off_bit));

// ==== cid_unit_tb.sv ====
// Self-checking bench for the unit, driven through its AHB-Lite window.
// Assumes the design and its checker are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) \
begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
        err_total++; \
        $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module cid_unit_tb;
    logic        hclk        = 1'b0;
    logic        hresetn     = 1'b0;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'h2;
    logic [31:0] hwdata      = 32'h0;
    logic        irq_request = 1'b0;
    logic        hready;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq_take;
    wire  [2:0]  mode;
    logic [31:0] rd;
    logic [15:0] exp_res     = 16'h0;
    logic [15:0] corners [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h007e, 16'h007f, 16'h0080,
        16'h0081, 16'h00fe, 16'h00ff, 16'h12fe, 16'h7ffe, 16'h7fff, 16'h8000, 16'h8001,
        16'hfffe, 16'hffff};
    integer      seed        = 32'h8f4fed24;
    int          err_total   = 0;
    int          num_checks  = 0;
    int          cyc         = 0;

    assign hready = hreadyout;
    always #10 hclk = ~hclk;

    cid_unit cid_unit_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .irq_request(irq_request), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .irq_take(irq_take), .global_irq_enable(mode[0]), .core_halt_bit(mode[1]),
        .oscillator_off_bit(mode[2]));

    // ------------------------------------------------------------------
    // Bus cycle, expectation and closing report
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    function automatic void model(input logic [3:0] op, input logic bm, input logic [15:0] dst,
        input logic [15:0] sw, input logic [19:0] pc, input logic [9:0] ofs,
        output logic [15:0] r, output logic [15:0] s, output logic [19:0] p);
        logic [15:0] top;
        logic [15:0] hi;
        logic [15:0] d;
        logic [15:0] k;
        logic        c;
        logic        z;
        logic        v;
        top = bm ? 16'h00ff : 16'hffff;
        hi  = bm ? 16'h0080 : 16'h8000;
        d   = dst & top;
        k   = {12'h0, op} - 16'h0001;
        r   = dst;
        s   = sw;
        p   = pc;
        c   = 1'b0;
        z   = 1'b0;
        v   = 1'b0;
        case (op)
            4'h1:
            begin
                r = (d - 16'h0002) & top;
                z = d == 16'h0002;
                c = d > 16'h0001;
                v = d == hi || d == hi + 16'h0001;
            end
            4'h2, 4'h3:
            begin
                r = (d + k) & top;
                z = r == 16'h0000;
                c = d > top - k;
                v = d >= hi - k && d < hi;
            end
            4'h4:
            begin
                r = ~d & top;
                z = r == 16'h0000;
                c = !z;
                v = (d & hi) != 16'h0000;
            end
            4'h5: s = sw & 16'hfff7;
            4'h6: s = sw | 16'h0008;
            4'h7, 4'h8: if (op == 4'h7 ? sw[0] : sw[1]) p = pc + {{9{ofs[9]}}, ofs, 1'b0};
            default: ;
        endcase
        if (op >= 4'h1 && op <= 4'h4) s = {sw[15:9], v, sw[7:3], (r & hi) != 16'h0000, z, c};
    endfunction

    task automatic run(input logic [3:0] op, input logic bm, input logic [15:0] dst,
        input logic [15:0] sw, input logic [9:0] ofs);
        logic [15:0] er;
        logic [15:0] es;
        logic [19:0] ep;
        logic [19:0] pc;
        pc = 20'($random(seed));
        irq_request <= 1'($random(seed));
        model(op, bm, dst, sw, pc, ofs, er, es, ep);
        if (op >= 4'h1 && op <= 4'h4) exp_res = er;
        bus(1'b1, 8'h00, {16'h0, dst});
        bus(1'b1, 8'h04, {16'h0, sw});
        bus(1'b1, 8'h08, {12'h0, pc});
        bus(1'b1, 8'h0c, {6'h0, ofs, 11'h0, bm, op});
        bus(1'b0, 8'h00, 32'h0);
        `CHK(rd, {16'h0, er})
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, {16'h0, es})
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, {12'h0, ep})
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rd, {16'h0, exp_res})
        `CHK(mode, es[5:3])
        if (op == 4'h6)
            `CHK(irq_take, 1'b0)
        else
            `CHK(irq_take, es[3] & irq_request)
    endtask

    task automatic results();
        $display("checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0)
        foreach (corners[i])
            for (int k = 2; k < 18; k++)
                run(k[4:1], k[0], corners[i], 16'($random(seed)) & 16'h013f,
                    i[0] ? 10'h200 : 10'h1ff);
        repeat (400)
            run(4'($random(seed)), 1'($random(seed)), 16'($random(seed)),
                16'($random(seed)) & 16'h013f, 10'($random(seed)));
        bus(1'b1, 8'h1c, 32'hffffffff);
        bus(1'b0, 8'h1c, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 8'h10, 32'h0000a5a5);
        bus(1'b0, 8'h10, 32'h0);
        `CHK(rd, {16'h0, exp_res})
        results();
    end

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            results();
        end
    end
endmodule
